/* light_pkg.sv */
// constants and types for the light sensor register access and conversion
// Summary of operation
// - pointer write alone, then read returns register
// - stop or repeated start between both accepted
// - pointer advances by one per byte read
// - bus address 26h write, 27h read
// - result high at 85h, low next
// - config bit 7 picks standard or continuous
// - standard mode publishes only after 100 ms frame
// - single measurement lasts about 300 us
// - result averages programmed count, up to 128
// - continuous mode measures back to back
// - idle means standby, emitter sink off
package light_pkg;
    // 7-bit form of 8-bit addresses 26h and 27h
    localparam logic [6:0] BUS_ADDR = 7'h13;

    localparam logic [7:0] REG_CMD = 8'h80;
    localparam logic [7:0] REG_CFG = 8'h84;
    localparam logic [7:0] REG_RES_HI = 8'h85;
    localparam logic [7:0] REG_RES_LO = 8'h86;
    localparam logic [7:0] PTR_RESET = 8'h80;
    localparam logic [7:0] CMD_RESET = 8'h00;
    localparam logic [7:0] CFG_RESET = 8'h00;

    localparam int CMD_ALS_EN_BIT = 0;
    localparam int CMD_RDY_BIT = 6;
    localparam int CFG_CONT_BIT = 7;
    localparam int CFG_AVG_LSB = 4;
    localparam int CFG_AVG_W = 3;
    localparam logic [3:0] BYTE_BITS = 4'h8;
    localparam logic [3:0] LAST_TX_BIT = 4'h7;

    localparam int CLK_MHZ = 100;
    localparam int MEAS_US = 300;
    localparam int FRAME_MS = 100;
    localparam int MEAS_CYC = MEAS_US * CLK_MHZ;
    localparam int FRAME_CYC = FRAME_MS * 1000 * CLK_MHZ;
    localparam int TMR_W = 24;
    localparam int ACC_W = 23;

    typedef enum logic [2:0] {
        I_IDLE,
        I_ADDR,
        I_AACK,
        I_RX,
        I_RACK,
        I_TX,
        I_TACK
    } i2c_state_t;

    typedef enum logic [1:0] {
        S_IDLE,
        S_MEAS,
        S_HOLD
    } seq_state_t;
endpackage

/* als_avg.sv */
// ambient light measurement sequencer with averaging
`timescale 1ns/1ps
module als_avg #(
    parameter int MEAS_CYC = light_pkg::MEAS_CYC,
    parameter int FRAME_CYC = light_pkg::FRAME_CYC
) (
    input wire logic sys_clk,
    input wire logic nrst,
    input wire logic en,
    input wire logic cont,
    input wire logic [light_pkg::CFG_AVG_W-1:0] avg_code,
    input wire logic [15:0] adc_data,
    output logic [15:0] result_q,
    output logic done_q,
    output logic meas_q
);
    localparam int TW = light_pkg::TMR_W;
    localparam int AW = light_pkg::ACC_W;

    light_pkg::seq_state_t st_q;
    logic [TW-1:0] mt_q;
    logic [TW-1:0] ft_q;
    logic [7:0] n_q;
    logic [AW-1:0] acc_q;
    logic [AW-1:0] sum_w;
    logic [7:0] n_last;
    logic meas_end;
    logic frame_end;

    function automatic logic [15:0] avg_of(
        input logic [AW-1:0] s,
        input logic [light_pkg::CFG_AVG_W-1:0] c
    );
        logic [AW-1:0] t;
        t = s >> c;
        return t[15:0];
    endfunction

    assign sum_w = acc_q + {{(AW-16){1'b0}}, adc_data};
    assign n_last = 8'((9'd1 << avg_code) - 9'd1);
    assign meas_end = (mt_q == TW'(MEAS_CYC - 1));
    assign frame_end = (ft_q == TW'(FRAME_CYC - 1));

    // frame timer only matters in standard mode
    always_ff @(posedge sys_clk or negedge nrst)
    begin
        if (!nrst)
            ft_q <= '0;
        else if (st_q == light_pkg::S_IDLE || frame_end)
            ft_q <= '0;
        else
            ft_q <= ft_q + TW'(1);
    end

    always_ff @(posedge sys_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            st_q <= light_pkg::S_IDLE;
            mt_q <= '0;
            n_q <= '0;
            acc_q <= '0;
            result_q <= '0;
            done_q <= 1'b0;
            meas_q <= 1'b0;
        end
        else
        begin
            done_q <= 1'b0;
            case (st_q)
                light_pkg::S_IDLE:
                begin
                    mt_q <= '0;
                    n_q <= '0;
                    acc_q <= '0;
                    if (en)
                    begin
                        st_q <= light_pkg::S_MEAS;
                        meas_q <= 1'b1;
                    end
                end
                light_pkg::S_MEAS:
                begin
                    mt_q <= meas_end ? '0 : mt_q + TW'(1);
                    if (!en)
                    begin
                        st_q <= light_pkg::S_IDLE;
                        meas_q <= 1'b0;
                    end
                    else if (meas_end && n_q == n_last)
                    begin
                        n_q <= '0;
                        if (cont)
                        begin
                            // next burst starts at once
                            result_q <= avg_of(sum_w, avg_code);
                            done_q <= 1'b1;
                            acc_q <= '0;
                        end
                        else
                        begin
                            acc_q <= sum_w;
                            st_q <= light_pkg::S_HOLD;
                            meas_q <= 1'b0;
                        end
                    end
                    else if (meas_end)
                    begin
                        acc_q <= sum_w;
                        n_q <= n_q + 8'd1;
                    end
                end
                light_pkg::S_HOLD:
                begin
                    mt_q <= '0;
                    if (!en)
                        st_q <= light_pkg::S_IDLE;
                    else if (frame_end)
                    begin
                        result_q <= avg_of(acc_q, avg_code);
                        done_q <= 1'b1;
                        acc_q <= '0;
                        st_q <= light_pkg::S_MEAS;
                        meas_q <= 1'b1;
                    end
                end
                default:
                begin
                    st_q <= light_pkg::S_IDLE;
                    meas_q <= 1'b0;
                end
            endcase
        end
    end
endmodule

/* light_sensor_top.sv */
// i2c target with register file driving the ambient light sequencer
`timescale 1ns/1ps
module light_sensor_top #(
    parameter int MEAS_CYC = light_pkg::MEAS_CYC,
    parameter int FRAME_CYC = light_pkg::FRAME_CYC
) (
    input wire logic sys_clk,
    input wire logic nrst,
    input wire logic scl_i,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe,
    input wire logic [15:0] adc_data,
    output logic meas_active,
    output logic standby,
    output logic led_sink_en
);
    logic scl_s1_q;
    logic scl_s2_q;
    logic scl_p_q;
    logic sda_s1_q;
    logic sda_s2_q;
    logic sda_p_q;
    logic start_w;
    logic stop_w;
    logic rise_w;
    logic fall_w;

    light_pkg::i2c_state_t st_q;
    logic [3:0] cnt_q;
    logic [7:0] sh_q;
    logic [7:0] tx_q;
    logic [7:0] ptr_q;
    logic first_q;
    logic rw_q;
    logic sda_oe_q;
    logic sda_o_q;
    logic [7:0] rd_byte;
    logic load_w;
    logic wr_w;
    logic wr_cmd_w;
    logic wr_cfg_w;
    logic rd_hi_w;
    logic byte_end_w;

    logic [7:0] cmd_q;
    logic [7:0] cfg_q;
    logic rdy_q;
    logic standby_q;
    logic led_q;
    logic [15:0] res_w;
    logic done_w;

    // pointer rolls over from ffh to 00h
    function automatic logic [7:0] next_ptr(input logic [7:0] p);
        return p + 8'h01;
    endfunction

    function automatic logic [3:0] next_cnt(input logic [3:0] c);
        return c + 4'h1;
    endfunction

    function automatic logic at_reg(
        input logic [7:0] p,
        input logic [7:0] a
    );
        return p == a;
    endfunction

    // first stage feeds only the second
    always_ff @(posedge sys_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            scl_s1_q <= 1'b1;
            scl_s2_q <= 1'b1;
            scl_p_q <= 1'b1;
            sda_s1_q <= 1'b1;
            sda_s2_q <= 1'b1;
            sda_p_q <= 1'b1;
        end
        else
        begin
            scl_s1_q <= scl_i;
            scl_s2_q <= scl_s1_q;
            scl_p_q <= scl_s2_q;
            sda_s1_q <= sda_i;
            sda_s2_q <= sda_s1_q;
            sda_p_q <= sda_s2_q;
        end
    end

    assign start_w = scl_s2_q && scl_p_q && sda_p_q && !sda_s2_q;
    assign stop_w = scl_s2_q && scl_p_q && !sda_p_q && sda_s2_q;
    assign rise_w = scl_s2_q && !scl_p_q;
    assign fall_w = !scl_s2_q && scl_p_q;

    always_comb
    begin
        case (ptr_q)
            light_pkg::REG_CMD:
                rd_byte = {cmd_q[7], rdy_q, cmd_q[5:0]};
            light_pkg::REG_CFG:
                rd_byte = cfg_q;
            light_pkg::REG_RES_HI:
                rd_byte = res_w[15:8];
            light_pkg::REG_RES_LO:
                rd_byte = res_w[7:0];
            default:
                rd_byte = 8'h00;
        endcase
    end

    // a byte is handed to the host on these edges
    assign load_w = fall_w && !start_w && !stop_w
        && ((st_q == light_pkg::I_AACK && rw_q)
        || st_q == light_pkg::I_TACK);
    assign wr_w = fall_w && st_q == light_pkg::I_RX
        && byte_end_w && !first_q;

    // bit counter reaches eight at the acknowledge slot
    assign byte_end_w = (cnt_q == light_pkg::BYTE_BITS);
    assign wr_cmd_w = wr_w && at_reg(ptr_q, light_pkg::REG_CMD);
    assign wr_cfg_w = wr_w && at_reg(ptr_q, light_pkg::REG_CFG);
    // ready drops as soon as the high byte is handed out
    assign rd_hi_w = load_w && at_reg(ptr_q, light_pkg::REG_RES_HI);

    always_ff @(posedge sys_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            st_q <= light_pkg::I_IDLE;
            cnt_q <= 4'h0;
            sh_q <= 8'h00;
            tx_q <= 8'h00;
            ptr_q <= light_pkg::PTR_RESET;
            first_q <= 1'b0;
            rw_q <= 1'b0;
            sda_oe_q <= 1'b0;
        end
        else if (start_w)
        begin
            // repeated start keeps the pointer
            st_q <= light_pkg::I_ADDR;
            cnt_q <= 4'h0;
            first_q <= 1'b1;
            sda_oe_q <= 1'b0;
        end
        else if (stop_w)
        begin
            st_q <= light_pkg::I_IDLE;
            sda_oe_q <= 1'b0;
        end
        else
        begin
            case (st_q)
                light_pkg::I_IDLE:
                    sda_oe_q <= 1'b0;
                light_pkg::I_ADDR,
                light_pkg::I_RX:
                begin
                    if (rise_w && !byte_end_w)
                    begin
                        sh_q <= {sh_q[6:0], sda_s2_q};
                        cnt_q <= next_cnt(cnt_q);
                    end
                    else if (fall_w && byte_end_w)
                    begin
                        cnt_q <= 4'h0;
                        if (st_q == light_pkg::I_RX)
                        begin
                            sda_oe_q <= 1'b1;
                            st_q <= light_pkg::I_RACK;
                            first_q <= 1'b0;
                            if (first_q)
                                ptr_q <= sh_q;
                            else
                                ptr_q <= next_ptr(ptr_q);
                        end
                        else if (sh_q[7:1] == light_pkg::BUS_ADDR)
                        begin
                            sda_oe_q <= 1'b1;
                            rw_q <= sh_q[0];
                            st_q <= light_pkg::I_AACK;
                        end
                        else
                            st_q <= light_pkg::I_IDLE;
                    end
                end
                light_pkg::I_AACK,
                light_pkg::I_TACK:
                begin
                    if (st_q == light_pkg::I_TACK && rise_w && sda_s2_q)
                        st_q <= light_pkg::I_IDLE;
                    else if (load_w)
                    begin
                        tx_q <= rd_byte;
                        sda_oe_q <= !rd_byte[7];
                        ptr_q <= next_ptr(ptr_q);
                        cnt_q <= 4'h0;
                        st_q <= light_pkg::I_TX;
                    end
                    else if (fall_w)
                    begin
                        sda_oe_q <= 1'b0;
                        cnt_q <= 4'h0;
                        st_q <= light_pkg::I_RX;
                    end
                end
                light_pkg::I_RACK:
                begin
                    if (fall_w)
                    begin
                        sda_oe_q <= 1'b0;
                        st_q <= light_pkg::I_RX;
                    end
                end
                light_pkg::I_TX:
                begin
                    if (fall_w && cnt_q == light_pkg::LAST_TX_BIT)
                    begin
                        sda_oe_q <= 1'b0;
                        st_q <= light_pkg::I_TACK;
                    end
                    else if (fall_w)
                    begin
                        tx_q <= {tx_q[6:0], 1'b0};
                        sda_oe_q <= !tx_q[6];
                        cnt_q <= next_cnt(cnt_q);
                    end
                end
                default:
                begin
                    st_q <= light_pkg::I_IDLE;
                    sda_oe_q <= 1'b0;
                end
            endcase
        end
    end

    // open drain: the driven level is always low
    always_ff @(posedge sys_clk or negedge nrst)
    begin
        if (!nrst)
            sda_o_q <= 1'b0;
        else
            sda_o_q <= 1'b0;
    end

    always_ff @(posedge sys_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            cmd_q <= light_pkg::CMD_RESET;
            cfg_q <= light_pkg::CFG_RESET;
        end
        else if (wr_cmd_w)
            cmd_q <= sh_q;
        else if (wr_cfg_w)
            cfg_q <= sh_q;
    end

    // a new result wins over a read of the high byte
    always_ff @(posedge sys_clk or negedge nrst)
    begin
        if (!nrst)
            rdy_q <= 1'b0;
        else if (done_w)
            rdy_q <= 1'b1;
        else if (rd_hi_w)
            rdy_q <= 1'b0;
    end

    // proximity is not handled here, so the sink stays off
    always_ff @(posedge sys_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            standby_q <= 1'b1;
            led_q <= 1'b0;
        end
        else
        begin
            standby_q <= !cmd_q[light_pkg::CMD_ALS_EN_BIT];
            led_q <= 1'b0;
        end
    end

    als_avg #(
        .MEAS_CYC(MEAS_CYC),
        .FRAME_CYC(FRAME_CYC)
    ) u_avg (
        .sys_clk(sys_clk),
        .nrst(nrst),
        .en(cmd_q[light_pkg::CMD_ALS_EN_BIT]),
        .cont(cfg_q[light_pkg::CFG_CONT_BIT]),
        .avg_code(cfg_q[light_pkg::CFG_AVG_LSB +: light_pkg::CFG_AVG_W]),
        .adc_data(adc_data),
        .result_q(res_w),
        .done_q(done_w),
        .meas_q(meas_active)
    );

    assign sda_o = sda_o_q;
    assign sda_oe = sda_oe_q;
    assign standby = standby_q;
    assign led_sink_en = led_q;
endmodule

/* light_sensor_top_sva.sv */
// port-level assertions for the light sensor top
`timescale 1ns/1ps
module light_sensor_top_sva #(
    parameter int MEAS_CYC = light_pkg::MEAS_CYC,
    parameter int FRAME_CYC = light_pkg::FRAME_CYC
) (
    input wire logic sys_clk,
    input wire logic nrst,
    input wire logic scl_i,
    input wire logic sda_i,
    input wire logic sda_o,
    input wire logic sda_oe,
    input wire logic [15:0] adc_data,
    input wire logic meas_active,
    input wire logic standby,
    input wire logic led_sink_en
);
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!nrst);

    int run_q;
    int oe_run_q;
    always_ff @(posedge sys_clk or negedge nrst)
    begin
        if (!nrst)
            run_q <= 0;
        else
            run_q <= meas_active ? run_q + 1 : 0;
    end
    always_ff @(posedge sys_clk or negedge nrst)
    begin
        if (!nrst)
            oe_run_q <= 0;
        else
            oe_run_q <= sda_oe ? oe_run_q + 1 : 0;
    end

    property p_sda_open_drain;
        sda_o == 1'b0;
    endproperty
    a_sda_open_drain: assert property (p_sda_open_drain)
        else $error("sda_o driven high");
    property p_emitter_off;
        led_sink_en == 1'b0;
    endproperty
    a_emitter_off: assert property (p_emitter_off)
        else $error("emitter sink enabled");
    property p_standby_quiet;
        meas_active |-> !standby;
    endproperty
    a_standby_quiet: assert property (p_standby_quiet)
        else $error("measuring in standby");
    property p_reset_state;
        $rose(nrst) |-> standby && !meas_active && !sda_oe;
    endproperty
    a_reset_state: assert property (p_reset_state)
        else $error("wrong state after reset");
    // an abort by disable may cut a measurement short
    property p_meas_length;
        $fell(meas_active) |-> (run_q % MEAS_CYC == 0) or ##[0:2] standby;
    endproperty
    a_meas_length: assert property (p_meas_length)
        else $error("burst not whole measurements");
    property p_oe_quiet_high;
        $rose(scl_i) |-> $stable(sda_oe)[*8];
    endproperty
    a_oe_quiet_high: assert property (p_oe_quiet_high)
        else $error("sda drive changed with scl high");
    property p_oe_needs_low;
        $changed(sda_oe) |-> !scl_i && !$past(scl_i);
    endproperty
    a_oe_needs_low: assert property (p_oe_needs_low)
        else $error("sda drive changed near scl high");
    property p_oe_bounded;
        oe_run_q < 200;
    endproperty
    a_oe_bounded: assert property (p_oe_bounded)
        else $error("sda held low too long");
endmodule

bind light_sensor_top light_sensor_top_sva #(.MEAS_CYC(MEAS_CYC),
    .FRAME_CYC(FRAME_CYC)) u_chk (.sys_clk(sys_clk), .nrst(nrst),
    .scl_i(scl_i), .sda_i(sda_i), .sda_o(sda_o), .sda_oe(sda_oe),
    .adc_data(adc_data), .meas_active(meas_active), .standby(standby),
    .led_sink_en(led_sink_en));

/* i2c_host.sv */
// host bus controller model on the two-wire register link
`timescale 1ns/1ps
module i2c_host (
    input wire logic clk,
    input wire logic sda,
    output logic scl = 1'b1,
    output logic sda_low = 1'b0
);
    task automatic tick(input int n);
        repeat (n) @(negedge clk);
    endtask
    // also a repeated start when entered with scl low
    task automatic start();
        sda_low = 1'b0;
        tick(5);
        scl = 1'b1;
        tick(10);
        sda_low = 1'b1;
        tick(10);
        scl = 1'b0;
        tick(5);
    endtask
    task automatic stop();
        sda_low = 1'b1;
        tick(5);
        scl = 1'b1;
        tick(10);
        sda_low = 1'b0;
        tick(10);
    endtask
    task automatic xbit(input logic b, output logic r);
        sda_low = !b;
        tick(5);
        scl = 1'b1;
        tick(10);
        r = sda;
        scl = 1'b0;
        tick(5);
    endtask
    // 8 bits msb first, then the acknowledge clock
    task automatic xbyte(input logic [7:0] d, input logic last,
                         output logic [7:0] q, output logic ack);
        for (int i = 7; i >= 0; i--)
            xbit(d[i], q[i]);
        xbit(last, ack);
    endtask
endmodule

/* tb.sv */
// self-checking bench for register reads and light conversion
`timescale 1ns/1ps
module tb;
    localparam int MC = 4;
    localparam int FC = 3000;
    logic sys_clk = 1'b0;
    logic nrst = 1'b0;
    logic [15:0] adc_data = 16'h0000;
    logic scl, h_low, sda_o, sda_oe, meas_active, standby, led_sink_en;
    wire sda = !(h_low || (sda_oe && !sda_o));
    int failures = 0;
    int num_checks = 0;
    int ph = 0;
    int bursts = 0;
    logic rnd_adc = 1'b0;
    logic was = 1'b0;
    logic ack;
    logic [22:0] acc = '0;
    logic [22:0] acc0;
    logic [15:0] adc_fix = 16'h0000;
    logic [15:0] exp_res;
    logic [7:0] q [$];

    always #5 sys_clk = ~sys_clk;

    light_sensor_top #(.MEAS_CYC(MC), .FRAME_CYC(FC)) DUT (
        .sys_clk(sys_clk), .nrst(nrst), .scl_i(scl), .sda_i(sda),
        .sda_o(sda_o), .sda_oe(sda_oe), .adc_data(adc_data),
        .meas_active(meas_active), .standby(standby),
        .led_sink_en(led_sink_en));
    i2c_host H (.clk(sys_clk), .sda(sda), .scl(scl), .sda_low(h_low));

    always @(negedge sys_clk)
        if (rnd_adc)
            adc_data <= 16'($urandom);
        else
            adc_data <= adc_fix;
    // sample on the last cycle of each single measurement
    always @(posedge sys_clk)
    begin
        if (meas_active && ph == MC - 1)
            acc = acc + 23'(adc_data);
        ph = meas_active ? (ph + 1) % MC : 0;
        if (was && !meas_active)
            bursts++;
        was = meas_active;
    end

    function automatic logic [15:0] avg(input logic [22:0] s, input int c);
        return 16'(s >> c);
    endfunction
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    task automatic chk(input string what, input logic [15:0] e,
                       input logic [15:0] g);
        num_checks++;
        if (g !== e)
        begin
            failures++;
            $display("wrong value %s: expected %h seen %h", what, e, g);
        end
    endtask
    task automatic sendb(input logic [7:0] d);
        logic [7:0] u;
        H.xbyte(d, 1'b1, u, ack);
        chk("ack", 16'h0000, 16'(ack));
    endtask
    task automatic wr(input logic [7:0] p, input logic [7:0] d);
        H.start();
        sendb(8'h26);
        sendb(p);
        sendb(d);
        H.stop();
    endtask
    // pointer alone, then n bytes; rs keeps a repeated start
    task automatic rd(input logic [7:0] p, input int n, input logic rs);
        logic [7:0] d;
        logic a;
        H.start();
        sendb(8'h26);
        sendb(p);
        if (!rs)
            H.stop();
        H.start();
        sendb(8'h27);
        q.delete();
        for (int i = 0; i < n; i++)
        begin
            H.xbyte(8'hff, i == n - 1, d, a);
            q.push_back(d);
        end
        H.stop();
    endtask
    task automatic poll_ready();
        for (int t = 0; t < 12; t++)
        begin
            rd(8'h80, 1, 1'b1);
            if (q[0][6] === 1'b1)
                break;
        end
        chk("ready", 16'h0041, 16'(q[0]));
    endtask

    initial
    begin
        int k;
        logic [7:0] u;
        void'($urandom(32'h6dec_0b3c));
        repeat (3) @(negedge sys_clk);
        nrst = 1'b1;
        H.tick(5);
        chk("standby", 16'h0001, 16'(standby));
        rd(8'h80, 7, 1'b0);
        foreach (q[i])
            chk("reset reg", 16'h0000, 16'(q[i]));
        H.start();
        H.xbyte(8'h28, 1'b1, u, ack);
        chk("foreign nack", 16'h0001, 16'(ack));
        H.stop();
        adc_fix = 16'($urandom);
        wr(8'h84, 8'h90);
        wr(8'h80, 8'h01);
        chk("standby", 16'h0000, 16'(standby));
        poll_ready();
        // result must survive the abort
        wr(8'h80, 8'h00);
        rd(8'h85, 2, 1'b1);
        chk("cont result", adc_fix, {q[0], q[1]});
        rnd_adc = 1'b1;
        for (int c = 0; c < 8; c++)
        begin
            wr(8'h84, 8'(c << 4));
            k = bursts;
            acc0 = acc;
            wr(8'h80, 8'h01);
            for (int t = 0; t < 8000 && bursts == k; t++)
                @(negedge sys_clk);
            chk("burst", 16'h0001, 16'(bursts > k));
            exp_res = avg(acc - acc0, c);
            rd(8'h80, 1, 1'b0);
            chk("early ready", 16'h0001, 16'(q[0]));
            poll_ready();
            rd(8'h85, 2, 1'b0);
            chk("avg result", exp_res, {q[0], q[1]});
            wr(8'h80, 8'h00);
        end
        chk("standby", 16'h0001, 16'(standby));
        tally_and_finish();
    end

    initial
    begin
        repeat (90000) @(posedge sys_clk);
        failures++;
        $display("watchdog expired");
        tally_and_finish();
    end
endmodule
